//--- scd_defines.svh
// Constants for the start generator with bus collision detection.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCD_ADR_CTRL   8'h00
`define SCD_ADR_BAUD   8'h04
`define SCD_ADR_STATUS 8'h08
`define SCD_ADR_MASK   8'h0C
`define SCD_ADR_TXBUF  8'h10
`define SCD_ADR_LINES  8'h14

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define SCD_CTRL_START 0
`define SCD_CTRL_EN    1
`define SCD_ST_EVENT   0
`define SCD_ST_BCOL    1
`define SCD_ST_WRITE_COLLISION_FLAG    2
`define SCD_ST_SDET    3
`define SCD_NFLAGS     4
`define SCD_BAUD_W     7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SCD_RST_CTRL   2'h0
`define SCD_RST_BAUD   7'h00
`define SCD_RST_FLAGS  4'h0
`define SCD_RST_TXBUF  8'h00
`define SCD_SETTLE     3'h4

`endif

//--- scd_pkg.sv
// Types shared by the start generator modules.
package scd_pkg;

	typedef enum logic [2:0] {
		SCD_IDLE,
		SCD_SETTLE,
		SCD_CHECK,
		SCD_FIRST,
		SCD_SECOND
	} scd_state_t;

	typedef logic [6:0] scd_baud_t;

endpackage

//--- scd_brg_if.sv
// Carrier between the start sequencer and its baud counter.
`timescale 1ns/100ps
interface scd_rate_if;
	logic                load;
	scd_pkg::scd_baud_t  reload;
	logic                stop;
	logic                expire;

	modport ctrl (output load, output reload, output stop, input expire);
	modport cnt  (input load, input reload, input stop, output expire);
endinterface

//--- scd_baud_counter.sv
// Reloadable baud-rate down-counter with a one-cycle expiry strobe.
`timescale 1ns/100ps
`include "scd_defines.svh"
module scd_baud_counter (
	input  wire logic clk_i,
	input  wire logic rst_i,
	scd_rate_if.cnt   rate
);
	scd_pkg::scd_baud_t count;
	scd_pkg::scd_baud_t next_count;
	logic               run;
	logic               next_run;

	// The strobe marks the cycle in which a running count stands at zero.
	assign rate.expire = run && (count == `SCD_RST_BAUD);

	always_comb begin
		next_count = count;
		next_run   = run;
		if (rst_i || rate.stop) begin
			next_run = 1'b0;
		end else if (rate.load) begin
			next_count = rate.reload;
			next_run   = 1'b1;
		end else if (rate.expire) begin
			next_run = 1'b0;
		end else if (run) begin
			next_count = count - 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= `SCD_RST_BAUD;
			run   <= 1'b0;
		end else begin
			count <= next_count;
			run   <= next_run;
		end
	end
endmodule

//--- scd_top.sv
// Start generator with bus collision detection behind a Wishbone slave.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "scd_defines.svh"
module scd_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	output logic             irq_o
);

	// ------------------------------------------------------------------
	// Line synchronisers
	// ------------------------------------------------------------------
	logic [1:0] line_meta;
	logic [1:0] line_sync;
	logic [1:0] line_raw;

	assign line_raw = {scl_i, sda_i};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					line_meta[gi] <= 1'b1;
					line_sync[gi] <= 1'b1;
				end else begin
					line_meta[gi] <= line_raw[gi];
					line_sync[gi] <= line_meta[gi];
				end
			end
		end
	endgenerate

	logic sda_s;
	logic scl_s;
	assign sda_s = line_sync[0];
	assign scl_s = line_sync[1];

	// ------------------------------------------------------------------
	// Bus access decoding
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
		hit = (adr == reg_adr);
	endfunction

	logic acc;
	logic wr;
	logic rd;
	assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr  = acc && wb_we_i && wb_sel_i[0];
	assign rd  = acc && !wb_we_i;

	// ------------------------------------------------------------------
	// Registers and sequencer state
	// ------------------------------------------------------------------
	scd_pkg::scd_state_t state;
	scd_pkg::scd_state_t next_state;
	logic                start_req;
	logic                next_start_req;
	logic                enable;
	logic                next_enable;
	scd_pkg::scd_baud_t  baud;
	scd_pkg::scd_baud_t  next_baud;
	logic [3:0]          status;
	logic [3:0]          next_status;
	logic [3:0]          mask;
	logic [3:0]          next_mask;
	logic [7:0]          txbuf;
	logic [7:0]          next_txbuf;
	logic                sda_low;
	logic                next_sda_low;
	logic                scl_low;
	logic                next_scl_low;
	logic [2:0]          settle;
	logic [2:0]          next_settle;
	logic                sda_prev;
	logic [31:0]         next_dat;
	logic                next_ack;
	logic                next_irq;
	logic                busy;
	logic                set_bcol;
	logic                set_event;
	logic                set_write_collision_flag;
	logic                set_sdet;
	logic                done;

	scd_rate_if rate ();

	scd_baud_counter u_rate (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.rate  (rate.cnt)
	);

	assign rate.reload = baud;
	assign busy       = (state != scd_pkg::SCD_IDLE);

	// ------------------------------------------------------------------
	// Start sequencer
	// ------------------------------------------------------------------
	always_comb begin
		next_state   = state;
		next_sda_low = sda_low;
		next_scl_low = scl_low;
		next_settle  = settle;
		rate.load    = 1'b0;
		rate.stop    = 1'b0;
		set_bcol     = 1'b0;
		done         = 1'b0;
		case (state)
			scd_pkg::SCD_IDLE: begin
				if (enable && start_req) begin
					// Own drives are dropped before the lines are judged.
					next_sda_low = 1'b0;
					next_scl_low = 1'b0;
					next_settle  = `SCD_SETTLE;
					next_state   = scd_pkg::SCD_SETTLE;
				end
			end
			scd_pkg::SCD_SETTLE: begin
				if (settle == 3'h0) begin
					next_state = scd_pkg::SCD_CHECK;
				end else begin
					next_settle = settle - 3'h1;
				end
			end
			scd_pkg::SCD_CHECK: begin
				if (!sda_s || !scl_s) begin
					set_bcol = 1'b1;
				end else begin
					rate.load  = 1'b1;
					next_state = scd_pkg::SCD_FIRST;
				end
			end
			scd_pkg::SCD_FIRST: begin
				// Another master is presumed to be sending a one.
				if (!scl_s && sda_s) begin
					set_bcol = 1'b1;
				end else if (!sda_s) begin
					// A nearby start by another master is not a collision.
					rate.load    = 1'b1;
					next_sda_low = 1'b1;
					next_state   = scd_pkg::SCD_SECOND;
				end else if (rate.expire) begin
					rate.load    = 1'b1;
					next_sda_low = 1'b1;
					next_state   = scd_pkg::SCD_SECOND;
				end
			end
			scd_pkg::SCD_SECOND: begin
				// SCL is deliberately not watched in this count.
				if (rate.expire) begin
					next_scl_low = 1'b1;
					done         = 1'b1;
					next_state   = scd_pkg::SCD_IDLE;
				end
			end
			default: begin
				next_state = scd_pkg::SCD_IDLE;
			end
		endcase
		if (set_bcol) begin
			rate.stop    = 1'b1;
			next_sda_low = 1'b0;
			next_scl_low = 1'b0;
			next_state   = scd_pkg::SCD_IDLE;
		end
		if (!enable) begin
			rate.stop    = 1'b1;
			next_sda_low = 1'b0;
			next_scl_low = 1'b0;
			next_state   = scd_pkg::SCD_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// Register file and flags
	// ------------------------------------------------------------------
	assign set_event = done;
	assign set_sdet  = sda_prev && !sda_s && scl_s;
	assign set_write_collision_flag  = wr && hit(wb_adr_i, `SCD_ADR_TXBUF) && busy;

	always_comb begin
		next_enable    = enable;
		next_start_req = start_req;
		next_baud      = baud;
		next_mask      = mask;
		next_txbuf     = txbuf;
		next_status    = status;
		if (wr && hit(wb_adr_i, `SCD_ADR_CTRL)) begin
			next_enable = wb_dat_i[`SCD_CTRL_EN];
			// The start bit cannot be rewritten while a start runs.
			if (!busy) begin
				next_start_req = wb_dat_i[`SCD_CTRL_START];
			end
		end
		if (done || set_bcol) begin
			next_start_req = 1'b0;
		end
		if (wr && hit(wb_adr_i, `SCD_ADR_BAUD) && !busy) begin
			next_baud = wb_dat_i[6:0];
		end
		if (wr && hit(wb_adr_i, `SCD_ADR_MASK)) begin
			next_mask = wb_dat_i[3:0];
		end
		if (wr && hit(wb_adr_i, `SCD_ADR_TXBUF) && !busy) begin
			next_txbuf = wb_dat_i[7:0];
		end
		// Only a status read clears flags; a new event wins over it.
		if (rd && hit(wb_adr_i, `SCD_ADR_STATUS)) begin
			// Only bits already reported are cleared, so none is lost.
			next_status = status & ~wb_dat_o[3:0];
		end
		if (set_event) begin
			next_status[`SCD_ST_EVENT] = 1'b1;
		end
		if (set_bcol) begin
			next_status[`SCD_ST_BCOL] = 1'b1;
		end
		if (set_write_collision_flag) begin
			next_status[`SCD_ST_WRITE_COLLISION_FLAG] = 1'b1;
		end
		if (set_sdet) begin
			next_status[`SCD_ST_SDET] = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------------
	always_comb begin
		next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_dat = 32'h0000_0000;
		if (hit(wb_adr_i, `SCD_ADR_CTRL)) begin
			next_dat[1:0] = {enable, start_req};
		end else if (hit(wb_adr_i, `SCD_ADR_BAUD)) begin
			next_dat[6:0] = baud;
		end else if (hit(wb_adr_i, `SCD_ADR_STATUS)) begin
			next_dat[3:0] = status;
		end else if (hit(wb_adr_i, `SCD_ADR_MASK)) begin
			next_dat[3:0] = mask;
		end else if (hit(wb_adr_i, `SCD_ADR_TXBUF)) begin
			next_dat[7:0] = txbuf;
		end else if (hit(wb_adr_i, `SCD_ADR_LINES)) begin
			next_dat[2:0] = {busy, scl_s, sda_s};
		end
		if (!next_ack) begin
			next_dat = 32'h0000_0000;
		end
		next_irq = |(next_status & next_mask);
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= scd_pkg::SCD_IDLE;
			enable    <= 1'b0;
			start_req <= 1'b0;
			baud      <= `SCD_RST_BAUD;
			status    <= `SCD_RST_FLAGS;
			mask      <= `SCD_RST_FLAGS;
			txbuf     <= `SCD_RST_TXBUF;
			sda_low   <= 1'b0;
			scl_low   <= 1'b0;
			settle    <= 3'h0;
			sda_prev  <= 1'b1;
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
			irq_o     <= 1'b0;
		end else begin
			state     <= next_state;
			enable    <= next_enable;
			start_req <= next_start_req;
			baud      <= next_baud;
			status    <= next_status;
			mask      <= next_mask;
			txbuf     <= next_txbuf;
			sda_low   <= next_sda_low;
			scl_low   <= next_scl_low;
			settle    <= next_settle;
			sda_prev  <= sda_s;
			wb_ack_o  <= next_ack;
			wb_dat_o  <= next_dat;
			irq_o     <= next_irq;
		end
	end

	// The pins only ever pull low; release leaves them to the pull-ups.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_o    <= 1'b1;
			sda_oe_o <= 1'b0;
			scl_o    <= 1'b1;
			scl_oe_o <= 1'b0;
		end else begin
			sda_o    <= !next_sda_low;
			sda_oe_o <= next_sda_low;
			scl_o    <= !next_scl_low;
			scl_oe_o <= next_scl_low;
		end
	end
endmodule

//--- scd_props.sv
// Port-level checks on the start generator with bus collision detection.
`timescale 1ns/100ps
`include "scd_defines.svh"
module scd_props (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        scl_i,
	input  wire logic        sda_oe_o,
	input  wire logic        scl_oe_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_start_wr;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == `SCD_ADR_CTRL && wb_dat_i[1:0] == 2'h3 ##1 wb_ack_o;
	endsequence
	sequence s_sda_down;
		!sda_oe_o ##1 sda_oe_o;
	endsequence

	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h00000000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
	property p_low_at_start;
		s_start_wr ##1 (!scl_i) [*8] |-> !sda_oe_o && !scl_oe_o;
	endproperty
	a_low_at_start: assert property (p_low_at_start)
		else $error("start driven on a low bus");
	property p_scl_before_sda;
		s_sda_down |-> $past(scl_i, 3);
	endproperty
	a_scl_before_sda: assert property (p_scl_before_sda)
		else $error("SDA driven after SCL was low");
	property p_sda_first;
		s_sda_down |-> !scl_oe_o;
	endproperty
	a_sda_first: assert property (p_sda_first)
		else $error("SCL driven before SDA");
	property p_no_coll_second;
		sda_oe_o && !scl_oe_o && !scl_i |=> sda_oe_o;
	endproperty
	a_no_coll_second: assert property (p_no_coll_second)
		else $error("start dropped in second count");
	property p_scl_done;
		s_sda_down |-> ##[1:140] scl_oe_o;
	endproperty
	a_scl_done: assert property (p_scl_done)
		else $error("SCL never driven");
endmodule

bind scd_top scd_props u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
	.scl_oe_o(scl_oe_o)
);

//--- scd_bus_model.sv
// Shared two-wire bus with pull-ups and a second master on it.
`timescale 1ns/100ps
module scd_bus_model (
	input  wire logic sda_o_i,
	input  wire logic sda_oe_i,
	input  wire logic scl_o_i,
	input  wire logic scl_oe_i,
	input  wire logic hold_sda_i,
	input  wire logic hold_scl_i,
	input  wire logic run_scl_i,
	output logic      sda_o,
	output logic      scl_o
);
	logic phase = 1'b0;

	// The other master's clock toggles only while its frame is open.
	initial begin
		#7;
		forever #160 phase = run_scl_i ? ~phase : 1'b0;
	end
	// A released line is pulled high; any party may pull it low.
	assign sda_o = !(sda_oe_i && !sda_o_i) && !hold_sda_i;
	assign scl_o = !(scl_oe_i && !scl_o_i) && !hold_scl_i &&
		!(run_scl_i && phase);
endmodule

//--- i2c_start_collision_detect_tb_top.sv
// Self-checking bench for the start generator with collision detection.
`timescale 1ns/100ps
`include "scd_defines.svh"
module i2c_start_collision_detect_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, sda_i, sda_o, sda_oe_o;
	logic        scl_i, scl_o, scl_oe_o, irq_o;
	logic        hold_sda = 1'b0;
	logic        hold_scl = 1'b0;
	logic        run_scl = 1'b0;
	logic [31:0] seed = 32'h8D4C470E;
	logic [31:0] exp_q[$];
	int          error_cnt = 0;
	int          n_tests = 0;

	always #20 clk_i = ~clk_i;

	scd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .scl_i(scl_i), .scl_o(scl_o),
		.scl_oe_o(scl_oe_o), .irq_o(irq_o));
	scd_bus_model bus_u (.sda_o_i(sda_o), .sda_oe_i(sda_oe_o),
		.scl_o_i(scl_o), .scl_oe_i(scl_oe_o), .hold_sda_i(hold_sda),
		.hold_scl_i(hold_scl), .run_scl_i(run_scl), .sda_o(sda_i),
		.scl_o(scl_i));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic hang;
		error_cnt++;
		$display("BAD wait exp done seen timeout");
		report_and_stop();
	endtask

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		logic ok;
		ok = 1'b0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge clk_i);
			ok = wb_ack_o === 1'b1;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (!ok)
			hang();
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_q.push_back(exp);
		wb(1'b0, adr, 32'h00000000);
	endtask

	task automatic wait_oe(input logic scl, input int lim);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(posedge clk_i);
			ok = (scl ? scl_oe_o : sda_oe_o) === 1'b1;
		end
		if (!ok)
			hang();
	endtask

	// Read data is compared against the oldest note when ack appears.
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
			chk("wb_dat_o", wb_dat_o, exp_q.pop_front());
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 28; a += 4)
			rd(a[7:0], a == 20 ? 32'h00000003 : 32'h00000000);
		seed = lfsr(seed);
		wb(1'b1, `SCD_ADR_BAUD, {25'h0, seed[6:0] | 7'h04});
		wb(1'b1, `SCD_ADR_MASK, 32'h0000000F);
		wb(1'b1, `SCD_ADR_TXBUF, {24'h0, seed[15:8]});
		wb(1'b1, 8'h18, 32'hFFFFFFFF);
		rd(`SCD_ADR_BAUD, {25'h0, seed[6:0] | 7'h04});
		rd(8'h18, 32'h00000000);
		wb(1'b1, `SCD_ADR_CTRL, 32'h00000003);
		wb(1'b1, `SCD_ADR_TXBUF, {24'h0, ~seed[15:8]});
		wait_oe(1'b1, 300);
		repeat (3) @(posedge clk_i);
		chk("irq_o", irq_o, 32'h00000001);
		chk("scl_o", scl_o, 32'h00000000);
		chk("sda_oe_o", sda_oe_o, 32'h00000001);
		rd(`SCD_ADR_TXBUF, {24'h0, seed[15:8]});
		rd(`SCD_ADR_STATUS, 32'h0000000D);
		rd(`SCD_ADR_CTRL, 32'h00000002);
		rd(`SCD_ADR_STATUS, 32'h00000000);
		repeat (2) @(posedge clk_i);
		chk("irq_o", irq_o, 32'h00000000);
		hold_scl <= 1'b1;
		wb(1'b1, `SCD_ADR_CTRL, 32'h00000003);
		repeat (20) @(posedge clk_i);
		chk("sda_oe_o", sda_oe_o, 32'h00000000);
		chk("scl_oe_o", scl_oe_o, 32'h00000000);
		rd(`SCD_ADR_CTRL, 32'h00000002);
		hold_scl <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd(`SCD_ADR_STATUS, 32'h00000002);
		wb(1'b1, `SCD_ADR_BAUD, 32'h0000007F);
		wb(1'b1, `SCD_ADR_CTRL, 32'h00000003);
		repeat (12) @(posedge clk_i);
		hold_scl <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk("sda_oe_o", sda_oe_o, 32'h00000000);
		rd(`SCD_ADR_STATUS, 32'h00000002);
		hold_scl <= 1'b0;
		wb(1'b1, `SCD_ADR_CTRL, 32'h00000003);
		repeat (12) @(posedge clk_i);
		hold_sda <= 1'b1;
		wait_oe(1'b0, 8);
		run_scl <= 1'b1;
		wait_oe(1'b1, 140);
		run_scl <= 1'b0;
		hold_sda <= 1'b0;
		rd(`SCD_ADR_STATUS, 32'h00000009);
		wb(1'b1, `SCD_ADR_CTRL, 32'h00000000);
		repeat (2) @(posedge clk_i);
		chk("sda_o", sda_o, 32'h00000001);
		chk("scl_oe_o", scl_oe_o, 32'h00000000);
		rd(`SCD_ADR_LINES, 32'h00000003);
		report_and_stop();
	end
endmodule
